// ---- core/ssd_byte_mem.sv ----
module ssd_byte_mem
   import ssd_pkg::*;
#(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 12
)
(
   input  wire logic              clk,
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic      [DATA_W-1:0] rd_data
);

   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] rd_data_reg;

   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data_reg <= mem[rd_addr];
   end

   assign rd_data = rd_data_reg;

endmodule : ssd_byte_mem

// ---- core/ssd_pkg.sv ----
package ssd_pkg;

   // ------------------------------------------------------------------
   // Register indices; the byte address on APB is four times the index.
   // ------------------------------------------------------------------
   localparam logic [5:0] IDX_IMAGE_BYTE_PORT    = 6'h00;
   localparam logic [5:0] IDX_BUFFERED_KBYTE     = 6'h01;
   localparam logic [5:0] IDX_STATUS             = 6'h02;
   localparam logic [5:0] IDX_TARGET_SELECT      = 6'h03;
   localparam logic [5:0] IDX_ADDR_HIGH          = 6'h04;
   localparam logic [5:0] IDX_ADDR_LOW           = 6'h05;
   localparam logic [5:0] IDX_DATA_PORT          = 6'h06;
   localparam logic [5:0] IDX_INPUT_CONFIG       = 6'h07;
   localparam logic [5:0] IDX_GAMMA_COLOR        = 6'h26;

   // ------------------------------------------------------------------
   // Field positions.
   // ------------------------------------------------------------------
   localparam int STAT_PAPER1_POS  = 0;
   localparam int STAT_PAPER2_POS  = 1;
   localparam int STAT_GPIO1_POS   = 2;
   localparam int STAT_GPIO2_POS   = 3;
   localparam int STAT_PAUSE_POS   = 4;
   localparam int STAT_SUPPLY_POS  = 5;
   localparam int TGT_SEL_POS      = 0;
   localparam int TGT_COLOR_LSB    = 1;
   localparam int ADDRH_DIR_POS    = 5;
   localparam int CFG_MODE_A_POS   = 4;
   localparam int CFG_DPI600_POS   = 5;
   localparam int GCOLOR_LSB       = 3;
   localparam int KBYTE_SHIFT      = 10;

   // ------------------------------------------------------------------
   // Reset values and indirect address limits.
   // ------------------------------------------------------------------
   localparam logic [7:0]  TARGET_RESET     = 8'h00;
   localparam logic [7:0]  ADDR_HIGH_RESET  = 8'h00;
   localparam logic [7:0]  ADDR_LOW_RESET   = 8'h00;
   localparam logic [7:0]  CONFIG_RESET     = 8'h00;
   localparam logic [7:0]  GCOLOR_RESET     = 8'h00;
   localparam logic [12:0] GAMMA_ADDR_MAX   = 13'd1023;
   localparam logic [12:0] COEF_ADDR_MAX_300 = 13'd2729;
   localparam logic [12:0] COEF_ADDR_MAX_600 = 13'd5459;

endpackage : ssd_pkg

// ---- core/ssd_regs.sv ----
// Overview of operation
// R1: A read of index 00 returns the next image byte from the buffer.
// R2: Index 01 reports the buffered image data in whole kilobytes.
// R3: Software reads the kilobyte count twice and trusts it only if equal.
// R4: Status bits 0 to 3 show paper sensor 1, 2 and general lines 1, 2.
// R5: An edge-sensitive input's status bit is cleared by a status read.
// R6: Status bit 4 is 1 when the scanner paused on this line, buffer full.
// R7: Status bit 5 latches a supply dip below 3V and a status read clears it.
// R8: Target bit 0 picks the gamma table (0) or SRAM coefficients (1).
// R9: Target bits 2:1 pick the colour: 00 red, 01 green, 10 blue.
// R10: In single-channel mode A the gamma colour comes from index 26 bits 4:3.
// R11: Index 04 holds address bits 12:8 in bits 4:0 and direction in bit 5.
// R12: Gamma locations run 0 to 1023 and stepping never carries the address past that.
// R13: Coefficient locations at 300 dpi run 0 to 2729.
// R14: Coefficient locations at 600 dpi run 0 to 5459; software stays inside.
// R15: Direction bit 1 makes data port accesses reads, 0 makes them writes.
// R16: The address steps after each gamma byte or each two coefficient bytes.
// R17: Each read of the image byte port removes that byte from the buffer.
module ssd_regs
   import ssd_pkg::*;
#(
   parameter int BUF_AW = 12
)
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        img_valid,
   input  wire logic [7:0]  img_data,
   output logic             img_ready,
   input  wire logic        paper_detect_in_1,
   input  wire logic        paper_detect_in_2,
   input  wire logic        gpio_in_1,
   input  wire logic        gpio_in_2,
   input  wire logic        pause_line_in,
   input  wire logic        supply_low_in,
   output logic             dp_target,
   output logic      [1:0]  dp_color,
   output logic      [12:0] dp_addr,
   output logic             dp_read_mode,
   output logic             dp_rd_strobe,
   input  wire logic [7:0]  dp_rdata,
   output logic             dp_wr_strobe,
   output logic      [7:0]  dp_wdata
);

   if (BUF_AW < KBYTE_SHIFT || BUF_AW > 18)
   begin : g_bad_depth
      $error("BUF_AW must lie between 10 and 18.");
   end

   localparam logic [BUF_AW:0] BUF_DEPTH = (BUF_AW+1)'(1 << BUF_AW);

   // ------------------------------------------------------------------
   // State.
   // ------------------------------------------------------------------
   typedef struct packed {
      logic              ack;
      logic [7:0]        rdata;
      logic              err;
      logic              rd_avail;
      logic [BUF_AW-1:0] wptr;
      logic [BUF_AW-1:0] rptr;
      logic [BUF_AW:0]   fill;
      logic [3:0]        prev_in;
      logic [3:0]        sense_lat;
      logic              pause;
      logic              pdrop;
      logic              target;
      logic [1:0]        color;
      logic [12:0]       addr;
      logic              dir;
      logic              byte_ph;
      logic [1:0]        gcolor;
      logic [7:0]        cfg;
      logic              dp_wr;
      logic [7:0]        dp_wdata;
   } ssd_state_type;

   ssd_state_type state_reg;
   ssd_state_type state_next;

   logic [7:0] mem_rdata;
   logic       push;
   logic       pop;
   logic       setup;
   logic       capture;
   logic       done;
   logic [5:0] idx;
   logic       idx_ok;
   logic [3:0] in_now;
   logic [3:0] rise;
   logic [3:0] sense_view;
   logic [7:0] status_val;

   // Highest legal indirect location for the current target.
   function automatic logic [12:0] ssd_addr_limit(input logic tgt,
                                                  input logic dpi600);
      logic [12:0] lim;
      lim = GAMMA_ADDR_MAX;
      if (tgt)
      begin
         lim = dpi600 ? COEF_ADDR_MAX_600 : COEF_ADDR_MAX_300;
      end
      return lim;
   endfunction : ssd_addr_limit

   // Next indirect address, held at the end of the legal range.
   function automatic logic [12:0] ssd_addr_step(input logic [12:0] a,
                                                 input logic [12:0] lim);
      logic [12:0] r;
      r = a;
      if (a < lim)
      begin
         r = a + 13'd1;
      end
      return r;
   endfunction : ssd_addr_step

   // ------------------------------------------------------------------
   // Image buffer storage.
   // ------------------------------------------------------------------
   ssd_byte_mem #(
      .DATA_W (8),
      .ADDR_W (BUF_AW)
   ) u_image_mem (
      .clk     (clk),
      .wr_en   (push),
      .wr_addr (state_reg.wptr),
      .wr_data (img_data),
      .rd_addr (state_reg.rptr),
      .rd_data (mem_rdata)
   );

   // ------------------------------------------------------------------
   // APB decode. Each access has one wait state: the first access cycle
   // captures read data, the second completes with pready.
   // ------------------------------------------------------------------
   assign idx     = paddr[7:2];
   assign idx_ok  = (paddr[1:0] == 2'b00) &&
                    (idx <= IDX_INPUT_CONFIG || idx == IDX_GAMMA_COLOR);
   assign setup   = psel && !penable;
   assign capture = psel && penable && !state_reg.ack;
   assign done    = psel && penable && state_reg.ack;
   assign pready  = done;
   assign pslverr = done && state_reg.err;
   assign prdata  = {24'h000000, state_reg.rdata};

   assign img_ready = (state_reg.fill != BUF_DEPTH);
   assign push      = img_valid && img_ready;
   assign pop       = done && !pwrite && idx_ok &&
                      idx == IDX_IMAGE_BYTE_PORT && state_reg.rd_avail; // R17

   assign dp_rd_strobe = setup && !pwrite && idx_ok &&
                         idx == IDX_DATA_PORT && state_reg.dir; // R15

   // ------------------------------------------------------------------
   // Status view.
   // ------------------------------------------------------------------
   assign in_now = {gpio_in_2, gpio_in_1, paper_detect_in_2,
                    paper_detect_in_1};
   assign rise   = in_now & ~state_reg.prev_in;

   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         sense_view[i] = state_reg.cfg[i] ? state_reg.sense_lat[i]
                                          : state_reg.prev_in[i]; // R4
      end
      status_val                  = 8'h00;
      status_val[STAT_GPIO2_POS:STAT_PAPER1_POS] = sense_view;
      status_val[STAT_PAUSE_POS]  = state_reg.pause;  // R6
      status_val[STAT_SUPPLY_POS] = state_reg.pdrop;  // R7
   end

   // ------------------------------------------------------------------
   // Next state.
   // ------------------------------------------------------------------
   always_comb
   begin
      state_next       = state_reg;
      state_next.dp_wr = 1'b0;
      state_next.ack   = capture;

      // Buffer pointers and fill level.
      if (push)
      begin
         state_next.wptr = state_reg.wptr + 1'b1;
      end
      if (pop)
      begin
         state_next.rptr = state_reg.rptr + 1'b1; // R1
      end
      state_next.fill = state_reg.fill + (push ? 1'b1 : 1'b0)
                                       - (pop ? 1'b1 : 1'b0); // R17

      // Availability of a byte is fixed at setup so that the word
      // captured from memory and the pop decision always agree.
      if (setup)
      begin
         state_next.rd_avail = (state_reg.fill != '0);
      end

      // Input tracking, edge latches and supply dip; a new event wins
      // over a clear in the same cycle.
      state_next.prev_in = in_now;
      state_next.pause   = pause_line_in; // R6
      if (done && !pwrite && idx_ok && idx == IDX_STATUS)
      begin
         state_next.sense_lat = state_reg.sense_lat & ~state_reg.cfg[3:0];
         state_next.pdrop     = 1'b0; // R7
      end
      state_next.sense_lat = state_next.sense_lat | rise; // R5
      if (supply_low_in)
      begin
         state_next.pdrop = 1'b1; // R7
      end

      // Read data capture in the first access cycle.
      if (capture)
      begin
         state_next.err   = !idx_ok;
         state_next.rdata = 8'h00;
         if (!pwrite && idx_ok)
         begin
            unique case (idx)
               IDX_IMAGE_BYTE_PORT:
               begin
                  if (state_reg.rd_avail)
                  begin
                     state_next.rdata = mem_rdata; // R1
                  end
               end
               IDX_BUFFERED_KBYTE:
               begin
                  state_next.rdata =
                     8'(state_reg.fill >> KBYTE_SHIFT); // R2
               end
               IDX_STATUS:
               begin
                  state_next.rdata = status_val; // R4
               end
               IDX_TARGET_SELECT:
               begin
                  state_next.rdata = {5'b00000, state_reg.color,
                                      state_reg.target};
               end
               IDX_ADDR_HIGH:
               begin
                  state_next.rdata = {2'b00, state_reg.dir,
                                      state_reg.addr[12:8]};
               end
               IDX_ADDR_LOW:
               begin
                  state_next.rdata = state_reg.addr[7:0];
               end
               IDX_DATA_PORT:
               begin
                  if (state_reg.dir)
                  begin
                     state_next.rdata = dp_rdata; // R15
                  end
               end
               IDX_INPUT_CONFIG:
               begin
                  state_next.rdata = state_reg.cfg;
               end
               IDX_GAMMA_COLOR:
               begin
                  state_next.rdata = {3'b000, state_reg.gcolor, 3'b000};
               end
               default:
               begin
                  state_next.rdata = 8'h00;
               end
            endcase
         end
      end

      // Register writes at completion.
      if (done && pwrite && idx_ok)
      begin
         unique case (idx)
            IDX_TARGET_SELECT:
            begin
               state_next.target  = pwdata[TGT_SEL_POS]; // R8
               state_next.color   = pwdata[TGT_COLOR_LSB+:2]; // R9
               state_next.byte_ph = 1'b0;
            end
            IDX_ADDR_HIGH:
            begin
               state_next.addr[12:8] = pwdata[4:0]; // R11
               state_next.dir        = pwdata[ADDRH_DIR_POS]; // R11
               state_next.byte_ph    = 1'b0;
            end
            IDX_ADDR_LOW:
            begin
               state_next.addr[7:0] = pwdata[7:0];
               state_next.byte_ph   = 1'b0;
            end
            IDX_INPUT_CONFIG:
            begin
               state_next.cfg = {2'b00, pwdata[5:0]};
            end
            IDX_GAMMA_COLOR:
            begin
               state_next.gcolor = pwdata[GCOLOR_LSB+:2]; // R10
            end
            default:
            begin
            end
         endcase
      end

      // Indirect data port: the access direction follows bit 5 of the
      // high address register; a mismatched access does nothing.
      if (done && idx_ok && idx == IDX_DATA_PORT && pwrite != state_reg.dir)
      begin
         if (pwrite)
         begin
            state_next.dp_wr    = 1'b1; // R15
            state_next.dp_wdata = pwdata[7:0];
         end
         if (!state_reg.target || state_reg.byte_ph)
         begin
            state_next.addr = ssd_addr_step(state_reg.addr,
               ssd_addr_limit(state_reg.target,
                              state_reg.cfg[CFG_DPI600_POS])); // R16 R12 R13
            state_next.byte_ph = 1'b0;
         end
         else
         begin
            state_next.byte_ph = 1'b1; // R16
         end
      end
   end

   // ------------------------------------------------------------------
   // State register.
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_reg        <= '0;
         state_reg.target <= TARGET_RESET[TGT_SEL_POS];
         state_reg.color  <= TARGET_RESET[TGT_COLOR_LSB+:2];
         state_reg.addr   <= {ADDR_HIGH_RESET[4:0], ADDR_LOW_RESET};
         state_reg.dir    <= ADDR_HIGH_RESET[ADDRH_DIR_POS];
         state_reg.cfg    <= CONFIG_RESET;
         state_reg.gcolor <= GCOLOR_RESET[GCOLOR_LSB+:2];
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------------
   // Indirect port outputs.
   // ------------------------------------------------------------------
   assign dp_target    = state_reg.target; // R8
   assign dp_color     = (state_reg.cfg[CFG_MODE_A_POS] && !state_reg.target)
                         ? state_reg.gcolor : state_reg.color; // R10 R9
   assign dp_addr      = state_reg.addr;
   assign dp_read_mode = state_reg.dir;
   assign dp_wr_strobe = state_reg.dp_wr;
   assign dp_wdata     = state_reg.dp_wdata;

endmodule : ssd_regs

// ---- verif/ssd_regs_asserts.sv ----
module ssd_regs_chk
   import ssd_pkg::*;
#(
   parameter int BUF_AW = 12
)
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        img_valid,
   input wire logic        img_ready,
   input wire logic        dp_target,
   input wire logic [12:0] dp_addr,
   input wire logic        dp_read_mode,
   input wire logic        dp_rd_strobe,
   input wire logic        dp_wr_strobe,
   input wire logic [7:0]  dp_wdata
);
   logic done;
   logic wr_dp;
   assign done  = psel && penable && pready;
   assign wr_dp = done && pwrite && paddr == 8'h18 && !dp_read_mode;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   AST_PRDATA_HIGH: assert property (done && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   AST_RD_STROBE: assert property (dp_rd_strobe |-> psel && !penable
      && !pwrite && dp_read_mode && paddr == 8'h18)
      else $error("data port read strobe without its read");
   AST_WR_STROBE: assert property (wr_dp |=> dp_wr_strobe
      && dp_wdata == $past(pwdata[7:0]))
      else $error("data port write not passed on");
   AST_WR_CAUSE: assert property (dp_wr_strobe |-> $past(wr_dp))
      else $error("data port write strobe without a write");
   AST_GAMMA_STEP: assert property (wr_dp && !dp_target
      && dp_addr < 13'd1023 |=> dp_addr == $past(dp_addr) + 13'd1)
      else $error("gamma address did not step by one");
   AST_GAMMA_HOLD: assert property (wr_dp && !dp_target
      && dp_addr == 13'd1023 |=> dp_addr == 13'd1023)
      else $error("gamma address passed its limit");
   AST_TARGET: assert property (done && pwrite && paddr == 8'h0C
      |=> dp_target == $past(pwdata[0]))
      else $error("target select not taken");
   AST_DIR: assert property (done && pwrite && paddr == 8'h10
      |=> dp_read_mode == $past(pwdata[5]))
      else $error("direction flag not taken");
   AST_IMG_POP: assert property (done && !pwrite && paddr == 8'h00
      && !img_ready && !img_valid |=> img_ready)
      else $error("image read did not free buffer space");
endmodule : ssd_regs_chk

bind ssd_regs ssd_regs_chk #(.BUF_AW(BUF_AW)) u_chk (.clk(clk), .srst(srst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .img_valid(img_valid), .img_ready(img_ready), .dp_target(dp_target),
   .dp_addr(dp_addr), .dp_read_mode(dp_read_mode),
   .dp_rd_strobe(dp_rd_strobe), .dp_wr_strobe(dp_wr_strobe),
   .dp_wdata(dp_wdata));

// ---- verif/ssd_scan_side.sv ----
module ssd_scan_side
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        fill_en,
   output logic             img_valid,
   output logic      [7:0]  img_data,
   input  wire logic        img_ready,
   input  wire logic        dp_rd_strobe,
   input  wire logic [12:0] dp_addr,
   output logic      [7:0]  dp_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_reg;
   // Outside fill_en the data lines show the inverted count so stale values never match.
   assign img_valid = fill_en;
   assign img_data  = fill_en ? cnt_reg : ~cnt_reg;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_reg  <= 8'h00;
         dp_rdata <= 8'h00;
      end
      else
      begin
         if (img_valid && img_ready)
            cnt_reg <= cnt_reg + 8'h01;
         if (dp_rd_strobe)
            dp_rdata <= dp_addr[7:0] ^ 8'hA5;
         else
            dp_rdata <= ~dp_rdata;
      end
   end
endmodule : ssd_scan_side

// ---- verif/tb.sv ----
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, srst, psel, penable, pwrite, err, pready, pslverr;
   logic        paper1, paper2, gpio1, gpio2, pause, supply, fill_en;
   logic        img_valid, img_ready, dp_target, dp_read_mode;
   logic        dp_rd_strobe, dp_wr_strobe;
   logic [7:0]  paddr, img_data, dp_rdata, dp_wdata;
   logic [31:0] pwdata, prdata, q;
   logic [1:0]  dp_color;
   logic [12:0] dp_addr;
   int          errors, checks, n;

   always #25 clk = ~clk;

   ssd_regs #(.BUF_AW(10)) dut (.clk(clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .img_valid(img_valid), .img_data(img_data), .img_ready(img_ready),
      .paper_detect_in_1(paper1), .paper_detect_in_2(paper2),
      .gpio_in_1(gpio1), .gpio_in_2(gpio2), .pause_line_in(pause),
      .supply_low_in(supply), .dp_target(dp_target), .dp_color(dp_color),
      .dp_addr(dp_addr), .dp_read_mode(dp_read_mode),
      .dp_rd_strobe(dp_rd_strobe), .dp_rdata(dp_rdata),
      .dp_wr_strobe(dp_wr_strobe), .dp_wdata(dp_wdata));

   ssd_scan_side u_side (.clk(clk), .srst(srst), .fill_en(fill_en),
      .img_valid(img_valid), .img_data(img_data), .img_ready(img_ready),
      .dp_rd_strobe(dp_rd_strobe), .dp_addr(dp_addr), .dp_rdata(dp_rdata));

   // -------------------------------------------------------------------
   // Reporting and bus tasks.
   // -------------------------------------------------------------------
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done

   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // The request stands until pready is sampled high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      // Outputs are looked at mid-cycle, where they have settled and
      // are the values that the next rising edge samples.
      @(negedge clk);
      while (pready !== 1'b1 && k < 20)
      begin
         @(negedge clk);
         k++;
      end
      if (pready !== 1'b1)
      begin
         errors++;
         test_done();
      end
      q   = prdata;
      err = pslverr;
      @(posedge clk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd

   // -------------------------------------------------------------------
   // Main sequence.
   // -------------------------------------------------------------------
   initial
   begin
      {clk, psel, penable, pwrite, paddr, pwdata, fill_en} = '0;
      {paper1, paper2, gpio1, gpio2, pause, supply} = '0;
      srst = 1'b1;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      rd(8'h0C);
      chk("target reset", q, 32'h0);
      rd(8'h10);
      chk("addr high reset", q, 32'h0);
      rd(8'h04);
      chk("kbyte empty", q, 32'h0);
      rd(8'h24);
      chk("unmapped err", 32'(err), 32'h1);
      chk("unmapped data", q, 32'h0);
      rd(8'h05);
      chk("misaligned err", 32'(err), 32'h1);
      @(posedge clk);
      {paper1, paper2, gpio1, gpio2, pause} <= 5'h1F;
      rd(8'h08);
      chk("status level", q, 32'h1F);
      {paper1, paper2, gpio1, gpio2, pause, supply} <= 6'h01;
      @(posedge clk);
      supply <= 1'b0;
      rd(8'h08);
      chk("supply dip", q, 32'h20);
      rd(8'h08);
      chk("supply cleared", q, 32'h0);
      wr(8'h1C, 8'h01);
      paper1 <= 1'b1;
      @(posedge clk);
      paper1 <= 1'b0;
      rd(8'h08);
      chk("edge captured", q, 32'h01);
      rd(8'h08);
      chk("edge cleared", q, 32'h0);
      wr(8'h0C, 8'h01);
      @(posedge clk);
      chk("target coef", 32'(dp_target), 32'h1);
      for (int c = 0; c < 3; c++)
      begin
         wr(8'h0C, 8'(c << 1));
         @(posedge clk);
         chk("colour", 32'(dp_color), 32'(c));
      end
      wr(8'h1C, 8'h10);
      wr(8'h98, 8'h08);
      wr(8'h0C, 8'h04);
      @(posedge clk);
      chk("mode A colour", 32'(dp_color), 32'h1);
      wr(8'h1C, 8'h00);
      wr(8'h10, 8'h03);
      wr(8'h14, 8'hFE);
      @(posedge clk);
      chk("addr", 32'(dp_addr), 32'h3FE);
      wr(8'h18, 8'h5A);
      @(posedge clk);
      chk("gamma step", 32'(dp_addr), 32'h3FF);
      chk("write byte", 32'(dp_wdata), 32'h5A);
      wr(8'h18, 8'hC3);
      @(posedge clk);
      chk("gamma limit", 32'(dp_addr), 32'h3FF);
      wr(8'h0C, 8'h01);
      wr(8'h10, 8'h00);
      wr(8'h14, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h18, 8'(i));
         @(posedge clk);
         chk("coef pair", 32'(dp_addr), 32'((i + 1) / 2));
      end
      wr(8'h0C, 8'h00);
      wr(8'h10, 8'h20);
      wr(8'h14, 8'h05);
      rd(8'h18);
      chk("port read", q, 32'hA0);
      @(posedge clk);
      chk("read step", 32'(dp_addr), 32'h6);
      wr(8'h18, 8'h77);
      @(posedge clk);
      chk("wrong direction", 32'(dp_addr), 32'h6);
      wr(8'h0C, 8'h01);
      wr(8'h10, 8'h2A);
      wr(8'h14, 8'hA9);
      rd(8'h18);
      rd(8'h18);
      @(posedge clk);
      chk("coef limit", 32'(dp_addr), 32'd2729);
      wr(8'h1C, 8'h20);
      wr(8'h10, 8'h35);
      wr(8'h14, 8'h53);
      rd(8'h18);
      rd(8'h18);
      @(posedge clk);
      chk("coef limit 600", 32'(dp_addr), 32'd5459);
      fill_en <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (img_ready !== 1'b0 && n < 1200);
      fill_en <= 1'b0;
      chk("buffer full", 32'(img_ready), 32'h0);
      rd(8'h04);
      chk("kbyte first", q, 32'h1);
      rd(8'h04);
      chk("kbyte second", q, 32'h1);
      rd(8'h00);
      chk("image byte 0", q, 32'h0);
      rd(8'h00);
      chk("image byte 1", q, 32'h1);
      rd(8'h04);
      chk("kbyte drained", q, 32'h0);
      test_done();
   end
endmodule : tb
